// *** periph_irq_regs.vh ***
// Register map, field positions, reset values and write masks of the
// peripheral interrupt flag and enable bank.
// Assumes an 8-bit register port with a 3-bit word address.
`ifndef PERIPH_IRQ_REGS_VH
`define PERIPH_IRQ_REGS_VH

// Register offsets on the register port.
`define OFS_ENABLE_TWO 3'h0
`define OFS_REQUEST_ONE 3'h1
`define OFS_REQUEST_TWO 3'h2
`define OFS_EVENT_STATUS 3'h3
`define OFS_EVENT_MASK 3'h4

// Bit positions in the first request register.
`define BIT_CONVERSION_DONE 6
`define BIT_SERIAL_RX_FULL 5
`define BIT_SERIAL_TX_EMPTY 4
`define BIT_SYNC_SERIAL_DONE 3
`define BIT_CAPTURE_COMPARE 2
`define BIT_PERIOD_MATCH 1
`define BIT_WIDE_TIMER_OVERFLOW 0

// Bit positions shared by the second enable and second request registers.
`define BIT_OSC_FAIL 7
`define BIT_COMPARATOR_TWO 6
`define BIT_COMPARATOR_ONE 5
`define BIT_NV_WRITE_DONE 4

// Event status bit that gathers all second-group flag events.
`define BIT_GROUP_TWO_EVENT 7

// Reset values.
`define RST_ENABLE_TWO 8'h00
`define RST_REQUEST_ONE 8'h00
`define RST_REQUEST_TWO 8'h00
`define RST_EVENT_STATUS 8'h00
`define RST_EVENT_MASK 8'h00

// Bits that software may write; all others read zero or are read-only.
`define WMASK_ENABLE_TWO 8'hF0
`define WMASK_REQUEST_ONE 8'h4F
`define WMASK_REQUEST_TWO 8'hF0
`define WMASK_EVENT_MASK 8'hFF

// Capture/compare unit mode codes.
`define CCP_MODE_CAPTURE 2'h0
`define CCP_MODE_COMPARE 2'h1
`define CCP_MODE_PWM 2'h2
`define CCP_MODE_OFF 2'h3

`endif

// *** peripheral_irq_enable_flag_bank.v ***
// Peripheral interrupt flag and enable bank: second enable register, first
// and second request registers, an event status register with its mask.
// Assumes peripherals give one-cycle event pulses on this clock, and that the
// core supplies the global and peripheral enable bits and the first enables.
// Outputs are registered: read data one cycle after the strobe, the core
// request and the level interrupt one cycle after their cause. Software is
// expected to clear a stale flag before it opens the matching enable.
`timescale 1ns/1ns
`include "periph_irq_regs.vh"

module peripheral_irq_enable_flag_bank (
    input wire clock,
    input wire rst,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire global_irq_en,
    input wire peripheral_irq_global_en,
    input wire [6:0] enable_one_in,
    input wire conversion_done_evt,
    input wire serial_rx_loaded_evt,
    input wire serial_rx_data_read,
    input wire serial_tx_emptied_evt,
    input wire serial_tx_data_write,
    input wire sync_serial_done_evt,
    input wire [1:0] ccp_mode,
    input wire capture_evt,
    input wire compare_evt,
    input wire period_match_evt,
    input wire wide_timer_overflow_evt,
    input wire osc_fail_evt,
    input wire comparator_one_evt,
    input wire comparator_two_evt,
    input wire nv_write_done_evt,
    output reg periph_irq_req,
    output reg irq
);

    // Register state. The first enable register lives in the core, so only
    // its seven bits arrive here as a level input; the event status and mask
    // pair is a local addition that drives the level interrupt output.
    reg [7:0] enable_two_reg;
    reg [7:0] request_one_reg;
    reg [7:0] request_two_reg;
    reg [7:0] event_status_reg;
    reg [7:0] event_mask_reg;

    // Next values and helper vectors.
    reg [7:0] enable_two_next;
    wire [7:0] request_one_next;
    wire [7:0] request_two_next;
    reg [7:0] event_status_next;
    reg [7:0] event_mask_next;
    reg [7:0] read_value;
    reg [7:0] set_one;
    reg [7:0] hw_clr_one;
    reg [7:0] set_two;
    reg capture_compare_evt;
    wire [7:0] wmask_one;
    wire [7:0] wmask_two;
    wire wr_enable_two;
    wire wr_request_one;
    wire wr_request_two;
    wire wr_event_mask;
    wire rd_event_status;
    wire [7:0] new_one;
    wire [7:0] new_two;
    wire [7:0] pending_one;
    wire [7:0] pending_two;
    wire [7:0] enable_one_full;
    wire [7:0] wr_bits_one;
    wire [7:0] wr_bits_two;
    reg periph_irq_next;
    reg irq_next;

    // Address decode; one strobe at a time hits at most one register.
    // Writes to the status offset and to offsets five to seven match nothing.
    assign wr_enable_two = reg_wr && (reg_addr == `OFS_ENABLE_TWO);
    assign wr_request_one = reg_wr && (reg_addr == `OFS_REQUEST_ONE);
    assign wr_request_two = reg_wr && (reg_addr == `OFS_REQUEST_TWO);
    assign wr_event_mask = reg_wr && (reg_addr == `OFS_EVENT_MASK);
    assign rd_event_status = reg_rd && (reg_addr == `OFS_EVENT_STATUS);

    // Writable bit masks as wires so the generate loops can index them.
    assign wmask_one = `WMASK_REQUEST_ONE;
    assign wmask_two = `WMASK_REQUEST_TWO;

    // Bits that a software write actually reaches in this cycle.
    assign wr_bits_one = {8{wr_request_one}} & wmask_one;
    assign wr_bits_two = {8{wr_request_two}} & wmask_two;

    // The capture/compare source depends on the unit's mode; in pulse-width
    // mode and when off the flag is left alone.
    always @* begin
        case (ccp_mode)
            `CCP_MODE_CAPTURE: begin
                capture_compare_evt = capture_evt;
            end
            `CCP_MODE_COMPARE: begin
                capture_compare_evt = compare_evt;
            end
            `CCP_MODE_PWM: begin
                // Pulse-width mode has no event of its own for this flag.
                capture_compare_evt = 1'b0;
            end
            default: begin
                capture_compare_evt = 1'b0;
            end
        endcase
    end

    // Hardware set vector for the first request register. Enables play no
    // part here, so a flag can be pending before software enables it.
    always @* begin
        set_one = 8'h00;
        set_one[`BIT_CONVERSION_DONE] = conversion_done_evt;
        set_one[`BIT_SERIAL_RX_FULL] = serial_rx_loaded_evt;
        set_one[`BIT_SERIAL_TX_EMPTY] = serial_tx_emptied_evt;
        set_one[`BIT_SYNC_SERIAL_DONE] = sync_serial_done_evt;
        set_one[`BIT_CAPTURE_COMPARE] = capture_compare_evt;
        set_one[`BIT_PERIOD_MATCH] = period_match_evt;
        set_one[`BIT_WIDE_TIMER_OVERFLOW] = wide_timer_overflow_evt;
    end

    // Hardware clears of the read-only serial flags: a receive data read
    // empties the receive buffer, a transmit data write fills the transmitter.
    // A same-cycle set still wins, so a byte that lands as the old one is read keeps it.
    always @* begin
        hw_clr_one = 8'h00;
        hw_clr_one[`BIT_SERIAL_RX_FULL] = serial_rx_data_read;
        hw_clr_one[`BIT_SERIAL_TX_EMPTY] = serial_tx_data_write;
    end

    // Hardware set vector for the second request register. Comparator events
    // pass straight through; detecting an output change is the comparator's job.
    always @* begin
        set_two = 8'h00;
        set_two[`BIT_OSC_FAIL] = osc_fail_evt;
        set_two[`BIT_COMPARATOR_TWO] = comparator_two_evt;
        set_two[`BIT_COMPARATOR_ONE] = comparator_one_evt;
        set_two[`BIT_NV_WRITE_DONE] = nv_write_done_evt;
    end

    // Per-bit flag update. A hardware set in the same cycle as a software
    // clear wins, so no event is lost. Unwritable bits keep their value,
    // and the top bit of the first register has no set source, so it stays 0.
    // The serial flags are outside the write mask and follow their pulses only.
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : flag_bit
            assign request_one_next[i] =
                ((wr_bits_one[i] ? reg_wdata[i]
                  : request_one_reg[i]) & ~hw_clr_one[i]) | set_one[i];
            assign request_two_next[i] =
                (wr_bits_two[i] ? reg_wdata[i]
                  : request_two_reg[i]) | set_two[i];
            // A flag counts as newly raised only on a rising transition.
            assign new_one[i] = request_one_next[i] & ~request_one_reg[i];
            assign new_two[i] = request_two_next[i] & ~request_two_reg[i];
        end
    endgenerate

    // Second enable register; its low nibble is not stored.
    // Dropping the low nibble at the write keeps the read path a plain copy.
    always @* begin
        enable_two_next = enable_two_reg;
        if (wr_enable_two) begin
            enable_two_next = reg_wdata & `WMASK_ENABLE_TWO;
        end
    end

    // Event mask register, same layout as the event status register.
    always @* begin
        event_mask_next = event_mask_reg;
        if (wr_event_mask) begin
            event_mask_next = reg_wdata & `WMASK_EVENT_MASK;
        end
    end

    // Event status: bits 6..0 latch new first-group flags, bit 7 latches any
    // new second-group flag. A read clears it, but a same-cycle event stays.
    // A limitation: a flag that is already set adds no new status bit on a
    // second event, so the status records raises of flags, not event counts.
    always @* begin
        event_status_next = rd_event_status ? 8'h00 : event_status_reg;
        event_status_next = event_status_next | {1'b0, new_one[6:0]};
        if (|new_two) begin
            event_status_next[`BIT_GROUP_TWO_EVENT] = 1'b1;
        end
    end

    // Pending requests use the next flag values, so the registered request
    // output lines up with the registered flags.
    assign enable_one_full = {1'b0, enable_one_in};
    assign pending_one = request_one_next & enable_one_full;
    assign pending_two = request_two_next & enable_two_next;

    // Next values of the core request and the level interrupt. Keeping them
    // apart from the flops leaves each output a plain register.
    always @* begin
        periph_irq_next = 1'b0;
        if (peripheral_irq_global_en && global_irq_en) begin
            periph_irq_next = |pending_one || |pending_two;
        end
        irq_next = |(event_status_next & event_mask_next);
    end

    // Read multiplexer; an unmapped address reads as zero.
    // Reads have no side effect here; only the status clear acts on a read.
    always @* begin
        case (reg_addr)
            `OFS_ENABLE_TWO: begin
                read_value = enable_two_reg;
            end
            `OFS_REQUEST_ONE: begin
                read_value = request_one_reg;
            end
            `OFS_REQUEST_TWO: begin
                read_value = request_two_reg;
            end
            `OFS_EVENT_STATUS: begin
                read_value = event_status_reg;
            end
            `OFS_EVENT_MASK: begin
                read_value = event_mask_reg;
            end
            default: begin
                read_value = 8'h00;
            end
        endcase
    end

    // Register update; all state clears on reset.
    // A synchronous reset keeps the whole bank in the one clock domain.
    always @(posedge clock) begin
        if (rst) begin
            enable_two_reg <= `RST_ENABLE_TWO;
            request_one_reg <= `RST_REQUEST_ONE;
            request_two_reg <= `RST_REQUEST_TWO;
            event_status_reg <= `RST_EVENT_STATUS;
            event_mask_reg <= `RST_EVENT_MASK;
        end else begin
            enable_two_reg <= enable_two_next;
            request_one_reg <= request_one_next;
            request_two_reg <= request_two_next;
            event_status_reg <= event_status_next;
            event_mask_reg <= event_mask_next;
        end
    end

    // Read data stands only in the cycle after the read strobe; otherwise
    // the port shows zero so stale data is never mistaken for an answer.
    // Zeroing the idle port costs one gate level but makes every answer explicit.
    always @(posedge clock) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= read_value;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Request to the core: an enabled flag reaches it only with both the
    // peripheral and the global enable set.
    always @(posedge clock) begin
        if (rst) begin
            periph_irq_req <= 1'b0;
        end else begin
            periph_irq_req <= periph_irq_next;
        end
    end

    // Level interrupt from sticky status and mask, taken from next values
    // so that it drops in the same cycle as the clearing read takes effect.
    always @(posedge clock) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_next;
        end
    end

endmodule

// *** periph_event_model.sv ***
// Model of the peripherals that pulse events into the bank.
// Assumes the bench names the events to fire one cycle ahead.
`timescale 1ns/1ns
module periph_event_model (
    input wire clock,
    input wire rst,
    input wire [13:0] fire,
    output reg [13:0] evt
);
    // One-cycle pulses, raised whatever any enable says.
    always @(posedge clock) begin
        if (rst) begin
            evt <= 14'h0000;
        end else begin
            evt <= fire;
        end
    end
endmodule

// *** periph_irq_bank_sva.sv ***
// Checker for the peripheral interrupt flag and enable bank.
// Assumes the bank's register port timing and its header.
`timescale 1ns/1ns
`include "periph_irq_regs.vh"
module periph_irq_bank_sva (
    input wire clock,
    input wire rst,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire global_irq_en,
    input wire peripheral_irq_global_en,
    input wire [1:0] ccp_mode,
    input wire capture_evt,
    input wire conversion_done_evt,
    input wire serial_rx_data_read,
    input wire serial_rx_loaded_evt,
    input wire nv_write_done_evt,
    input wire periph_irq_req,
    input wire irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // A read one idle cycle after the cause, so no write can clear in between.
    sequence s_rd(a);
        !reg_wr ##1 (reg_rd && reg_addr == a);
    endsequence
    a_req_needs_enables: assert property (
        periph_irq_req |-> $past(global_irq_en) && $past(peripheral_irq_global_en))
        else $error("request without both enables");
    a_enable_write_read: assert property (
        reg_wr && reg_addr == `OFS_ENABLE_TWO ##1 s_rd(`OFS_ENABLE_TWO)
        |=> reg_rdata == ($past(reg_wdata, 3) & 8'hF0)) else $error("enable readback");
    a_enable_low_zero: assert property (
        reg_rd && reg_addr == `OFS_ENABLE_TWO |=> reg_rdata[3:0] == 4'h0)
        else $error("enable low bits not zero");
    a_request_top_zero: assert property (
        reg_rd && reg_addr == `OFS_REQUEST_ONE |=> !reg_rdata[7]) else $error("bit 7 set");
    a_conv_flag_set: assert property (
        conversion_done_evt ##1 s_rd(`OFS_REQUEST_ONE) |=> reg_rdata[6])
        else $error("conversion flag missing");
    a_rx_read_clears: assert property (
        serial_rx_data_read && !serial_rx_loaded_evt ##1 s_rd(`OFS_REQUEST_ONE)
        |=> !reg_rdata[5]) else $error("receive flag not cleared");
    a_capture_sets: assert property (
        capture_evt && ccp_mode == `CCP_MODE_CAPTURE ##1 s_rd(`OFS_REQUEST_ONE)
        |=> reg_rdata[2]) else $error("capture flag missing");
    a_nv_flag_set: assert property (
        nv_write_done_evt ##1 s_rd(`OFS_REQUEST_TWO) |=> reg_rdata[4])
        else $error("write done flag missing");
    a_mask_clear_quiet: assert property (
        reg_wr && reg_addr == `OFS_EVENT_MASK && reg_wdata == 8'h00 |=> !irq)
        else $error("irq with empty mask");
endmodule
bind peripheral_irq_enable_flag_bank periph_irq_bank_sva u_sva (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .global_irq_en(global_irq_en), .ccp_mode(ccp_mode),
    .peripheral_irq_global_en(peripheral_irq_global_en), .capture_evt(capture_evt),
    .conversion_done_evt(conversion_done_evt), .serial_rx_data_read(serial_rx_data_read),
    .serial_rx_loaded_evt(serial_rx_loaded_evt), .nv_write_done_evt(nv_write_done_evt),
    .periph_irq_req(periph_irq_req), .irq(irq));

// *** peripheral_irq_enable_flag_bank_test.sv ***
// Self-checking bench for the peripheral interrupt flag and enable bank.
// Assumes the header, event model and checker are compiled first.
`timescale 1ns/1ns
`include "periph_irq_regs.vh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module peripheral_irq_enable_flag_bank_test;
    logic clock = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, rd_d = 1'h0;
    logic global_irq_en = 1'h0, peripheral_irq_global_en = 1'h0, periph_irq_req, irq;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, w;
    logic [1:0] ccp_mode = 2'h0;
    logic [6:0] en_one = 7'h00;
    logic [13:0] fire = 14'h0000, evt;
    logic [8:0] expq[$];
    logic [8:0] e;
    int n_mismatch = 0, compares = 0;
    initial forever #25 clock = ~clock;
    periph_event_model u_periph_event_model (.clock(clock), .rst(rst), .fire(fire), .evt(evt));
    peripheral_irq_enable_flag_bank u_peripheral_irq_enable_flag_bank (.clock(clock),
        .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_irq_en(global_irq_en),
        .peripheral_irq_global_en(peripheral_irq_global_en), .enable_one_in(en_one),
        .wide_timer_overflow_evt(evt[0]), .period_match_evt(evt[1]), .capture_evt(evt[2]),
        .compare_evt(evt[3]), .sync_serial_done_evt(evt[4]), .serial_tx_emptied_evt(evt[5]),
        .serial_rx_loaded_evt(evt[6]), .conversion_done_evt(evt[7]),
        .nv_write_done_evt(evt[8]), .comparator_one_evt(evt[9]),
        .comparator_two_evt(evt[10]), .osc_fail_evt(evt[11]), .serial_rx_data_read(evt[12]),
        .serial_tx_data_write(evt[13]), .ccp_mode(ccp_mode), .periph_irq_req(periph_irq_req),
        .irq(irq));
    // One bus cycle; a read notes its expected data, bit 8 marking it as checked.
    task bus(input logic wr, input logic [2:0] a, input logic [7:0] d, input logic [8:0] x);
        @(posedge clock);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        if (!wr) expq.push_back(x);
        @(posedge clock);
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        bus(1'h1, a, d, 9'h000);
    endtask
    task rd(input logic [2:0] a, input logic [7:0] x);
        bus(1'h0, a, 8'h00, {1'h1, x});
    endtask
    // Ask the model for pulses and return once the bank has taken them.
    task pulse(input logic [13:0] m);
        @(posedge clock);
        fire <= m;
        @(posedge clock);
        fire <= 14'h0000;
        @(posedge clock);
    endtask
    // Outputs are registered, so two edges are ample for them to settle.
    task look;
        repeat (2) @(posedge clock);
        #1;
    endtask
    task final_report;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe, so sample there.
    always @(posedge clock) begin
        rd_d <= reg_rd;
        if (rd_d) begin
            e = expq.pop_front();
            if (e[8]) `CHK("reg_rdata", e[7:0], reg_rdata)
        end
    end
    initial begin
        repeat (2000) @(posedge clock);
        n_mismatch++;
        final_report;
    end
    initial begin
        w = $urandom(32'hDE0F);
        repeat (8) @(posedge clock);
        rst <= 1'h0;
        for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            w = $urandom;
            wr(`OFS_ENABLE_TWO, w);
            rd(`OFS_ENABLE_TWO, w & 8'hF0);
        end
        $display("test enables done");
        // Only the event that suits the unit mode may set its flag.
        for (int i = 0; i < 4; i++) begin
            ccp_mode <= i[1:0];
            pulse(i == 1 ? 14'h0008 : 14'h0004);
            rd(`OFS_REQUEST_ONE, i < 2 ? 8'h04 : 8'h00);
            wr(`OFS_REQUEST_ONE, 8'h00);
        end
        ccp_mode <= `CCP_MODE_COMPARE;
        pulse(14'h00FB);
        rd(`OFS_REQUEST_ONE, 8'h7F);
        wr(`OFS_REQUEST_ONE, 8'h00);
        rd(`OFS_REQUEST_ONE, 8'h30);
        pulse(14'h3000);
        rd(`OFS_REQUEST_ONE, 8'h00);
        wr(`OFS_REQUEST_ONE, 8'hFF);
        rd(`OFS_REQUEST_ONE, 8'h4F);
        wr(`OFS_REQUEST_ONE, 8'h00);
        pulse(14'h0F00);
        rd(`OFS_REQUEST_TWO, 8'hF0);
        wr(`OFS_REQUEST_TWO, 8'h00);
        rd(`OFS_REQUEST_TWO, 8'h00);
        $display("test flags done");
        wr(`OFS_ENABLE_TWO, 8'h00);
        pulse(14'h0100);
        wr(`OFS_ENABLE_TWO, 8'h10);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            global_irq_en <= i[0];
            peripheral_irq_global_en <= i[1];
            look;
            `CHK("periph_irq_req", i == 3, periph_irq_req)
        end
        wr(`OFS_ENABLE_TWO, 8'h00);
        look;
        `CHK("periph_irq_req", 1'h0, periph_irq_req)
        $display("test request done");
        // Stale status is drained before the mask is opened.
        bus(1'h0, `OFS_EVENT_STATUS, 8'h00, 9'h000);
        wr(`OFS_EVENT_MASK, 8'h00);
        pulse(14'h0002);
        look;
        `CHK("irq", 1'h0, irq)
        wr(`OFS_EVENT_MASK, 8'h02);
        look;
        `CHK("irq", 1'h1, irq)
        rd(`OFS_EVENT_STATUS, 8'h02);
        look;
        `CHK("irq", 1'h0, irq)
        // First-group enables come from outside; only flag bit 1 is pending now.
        w = $urandom;
        @(posedge clock);
        en_one <= w[6:0] | 7'h02;
        look;
        `CHK("periph_irq_req", 1'h1, periph_irq_req)
        @(posedge clock);
        en_one <= w[6:0] & 7'h7D;
        look;
        `CHK("periph_irq_req", 1'h0, periph_irq_req)
        $display("test interrupt done");
        final_report;
    end
endmodule
